// File: rtl/stu_map.svh
// Offsets, field positions, reset values and widths of the translator
`ifndef STU_MAP_SVH
`define STU_MAP_SVH
`define STU_NSEG 6
`define STU_SEG_W 3
`define STU_SEG_CODE 3'h0
`define STU_SEG_STACK 3'h1
`define STU_SEG_DATA0 3'h2
`define STU_SEL_W 16
`define STU_OFF_W 32
`define STU_LIM_W 20
`define STU_PG_SH 12
`define STU_PG_ONES 12'hfff
`define STU_DESC_SH 3
`define STU_IDX 15:3
`define STU_TI 2
`define STU_RPL 1:0
`define STU_D_LIM_LO 15:0
`define STU_D_BASE_LO 31:16
`define STU_D_BASE_MID 39:32
`define STU_D_TYPE 43:40
`define STU_D_S 44
`define STU_D_DPL 46:45
`define STU_D_LIM_HI 51:48
`define STU_D_G 55
`define STU_D_BASE_HI 63:56
`define STU_T_CODE 3
`define STU_T_XDOWN 2
`define STU_A_GTB 8'h00
`define STU_A_LTB 8'h04
`define STU_A_CTRL 8'h08
`define STU_A_STAT 8'h0c
`define STU_A_SEL0 8'h10
`define STU_CTRL_PG 0
`define STU_CTRL_CPL 2:1
`define STU_CTRL_MASK 32'h0000_0007
`define STU_RST_LIM 20'hfffff
`define STU_RST_WORD 32'h0000_0000
`endif

// File: rtl/stu_pkg.sv
// Types shared by the segment translation unit
`include "stu_map.svh"
package stu_pkg;
  typedef enum logic [1:0] {
    STU_IDLE = 2'b00,
    STU_FETCH = 2'b01
  } stu_state_t;
  typedef enum logic [2:0] {
    STU_F_NONE = 3'b000,
    STU_F_NULL = 3'b001,
    STU_F_LIMIT = 3'b010,
    STU_F_PRIV = 3'b011,
    STU_F_LDNULL = 3'b100
  } stu_fault_t;
  typedef struct packed {
    logic [`STU_OFF_W-1:0] base;
    logic [`STU_LIM_W-1:0] limit;
    logic gran;
    logic xdown;
    logic [1:0] dpl;
  } stu_desc_t;
  typedef struct packed {
    logic [`STU_SEL_W-1:0] sel;
    logic usable;
    stu_desc_t desc;
  } stu_seg_t;
  typedef struct packed {
    logic far;
    logic [`STU_SEG_W-1:0] seg;
    logic [`STU_SEL_W-1:0] sel;
  } stu_ld_t;
  typedef struct packed {
    logic [`STU_SEG_W-1:0] seg;
    logic [`STU_OFF_W-1:0] off;
    logic [1:0] len;
  } stu_acc_t;
endpackage : stu_pkg

// File: rtl/stu_top.sv
// Segment translation unit: selector loads, limit and privilege checks
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "stu_map.svh"
// How it works
// - Every access offset is checked against the segment limit.
// - Logical address is a 16-bit selector and 32-bit offset.
// - Linear address is offset plus the cached segment base.
// - Six segment registers: code, stack, four data.
// - Selector load fetches descriptor into the hidden part.
// - Translation uses only the cached copy until reloaded.
// - Explicit loads and far transfers both load segments.
// - Descriptor address is table base plus index times eight.
// - Table base comes from global or local base register.
// - Table-select bit zero picks global, one picks local.
// - Index reaches any of 8192 eight-byte entries.
// - Weaker requester privilege governs the access.
// - Fault when the weaker privilege is insufficient.
// - Index zero in global table is the null selector.
// - Null load into data registers completes quietly.
// - Access through a null register faults, no access.
// - Paging off: linear is physical; on: to pager.
// - Base from three fields, limit from two fields.
// - Granular limit scales by 4096, low bits ignored.
// - Expand-down segments accept only above the limit.
module stu_top import stu_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ld_valid,
  input wire stu_ld_t ld_req,
  output logic ld_ready,
  output logic ld_done,
  output logic ld_fault,
  output logic df_req,
  output logic [31:0] df_addr,
  input wire logic df_ack,
  input wire logic [63:0] df_data,
  input wire logic acc_valid,
  input wire stu_acc_t acc_req,
  output logic phys_valid,
  output logic page_valid,
  output logic [31:0] out_addr,
  output logic gp_fault,
  output stu_fault_t fault_kind
);

  function automatic logic hit(input logic [31:0] a,
                               input logic [7:0] off);
    hit = (a[31:8] == 24'h00_0000) && (a[7:0] == off);
  endfunction : hit

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  function automatic logic is_null(input logic [15:0] s);
    is_null = (s[`STU_IDX] == 13'h0000) && !s[`STU_TI];
  endfunction : is_null

  // APB register file
  logic [31:0] gtb_q, gtb_d;
  logic [31:0] ltb_q, ltb_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  stu_fault_t last_q, last_d;
  stu_seg_t seg_q [`STU_NSEG];
  stu_seg_t seg_d [`STU_NSEG];
  stu_state_t st_q, st_d;

  logic setup;
  logic wr_acc;
  logic mapped;
  logic [31:0] rd_val;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && !pslverr_q;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  always_comb begin
    mapped = 1'b1;
    rd_val = `STU_RST_WORD;
    if (hit(paddr, `STU_A_GTB)) begin
      rd_val = gtb_q;
    end else if (hit(paddr, `STU_A_LTB)) begin
      rd_val = ltb_q;
    end else if (hit(paddr, `STU_A_CTRL)) begin
      rd_val = ctrl_q;
    end else if (hit(paddr, `STU_A_STAT)) begin
      rd_val = {28'h000_0000, st_q == STU_FETCH, last_q};
    end else begin
      mapped = 1'b0;
      for (int i = 0; i < `STU_NSEG; i++) begin
        if (hit(paddr, 8'(`STU_A_SEL0 + 4 * i))) begin
          mapped = 1'b1;
          rd_val = {16'h0000, seg_q[i].sel};
        end
      end
    end
  end

  // Read data and error latched in setup so the answer is a flop
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    gtb_d = gtb_q;
    ltb_d = ltb_q;
    ctrl_d = ctrl_q;
    if (setup) begin
      prdata_d = pwrite ? `STU_RST_WORD : rd_val;
      pslverr_d = !mapped;
    end
    if (wr_acc && hit(paddr, `STU_A_GTB)) begin
      gtb_d = merge(gtb_q, pwdata, pstrb);
    end
    if (wr_acc && hit(paddr, `STU_A_LTB)) begin
      ltb_d = merge(ltb_q, pwdata, pstrb);
    end
    if (wr_acc && hit(paddr, `STU_A_CTRL)) begin
      ctrl_d = merge(ctrl_q, pwdata, pstrb) & `STU_CTRL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gtb_q <= `STU_RST_WORD;
      ltb_q <= `STU_RST_WORD;
      ctrl_q <= `STU_RST_WORD;
      prdata_q <= `STU_RST_WORD;
      pslverr_q <= 1'b0;
    end else begin
      gtb_q <= gtb_d;
      ltb_q <= ltb_d;
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Selector loads
  logic [`STU_SEG_W-1:0] tgt_q, tgt_d;
  logic [15:0] sel_q, sel_d;
  logic [31:0] dfa_q, dfa_d;
  logic done_q, done_d;
  logic lflt_q, lflt_d;
  logic [`STU_SEG_W-1:0] ld_tgt;
  logic [31:0] tbase;
  stu_desc_t fetched;
  logic [3:0] dtype;

  assign ld_ready = (st_q == STU_IDLE);
  assign df_req = (st_q == STU_FETCH);
  assign df_addr = dfa_q;
  assign ld_done = done_q;
  assign ld_fault = lflt_q;

  // Far transfers always reload the code register
  assign ld_tgt = ld_req.far ? `STU_SEG_CODE : ld_req.seg;
  assign tbase = ld_req.sel[`STU_TI] ? ltb_q : gtb_q;
  assign dtype = df_data[`STU_D_TYPE];

  always_comb begin
    fetched.base = {df_data[`STU_D_BASE_HI], df_data[`STU_D_BASE_MID],
                    df_data[`STU_D_BASE_LO]};
    fetched.limit = {df_data[`STU_D_LIM_HI],
                     df_data[`STU_D_LIM_LO]};
    fetched.gran = df_data[`STU_D_G];
    fetched.xdown = df_data[`STU_D_S] && !dtype[`STU_T_CODE]
                    && dtype[`STU_T_XDOWN];
    fetched.dpl = df_data[`STU_D_DPL];
  end

  always_comb begin
    st_d = st_q;
    tgt_d = tgt_q;
    sel_d = sel_q;
    dfa_d = dfa_q;
    done_d = 1'b0;
    lflt_d = 1'b0;
    for (int i = 0; i < `STU_NSEG; i++) begin
      seg_d[i] = seg_q[i];
    end
    case (st_q)
      STU_IDLE: begin
        if (ld_valid && ld_tgt < `STU_SEG_W'(`STU_NSEG)) begin
          if (is_null(ld_req.sel)) begin
            if (ld_tgt == `STU_SEG_CODE || ld_tgt == `STU_SEG_STACK) begin
              lflt_d = 1'b1;
            end else begin
              seg_d[ld_tgt].sel = ld_req.sel;
              seg_d[ld_tgt].usable = 1'b0;
              done_d = 1'b1;
            end
          end else begin
            tgt_d = ld_tgt;
            sel_d = ld_req.sel;
            // 13-bit index reaches 8192 entries of eight bytes
            dfa_d = tbase + {16'h0000, ld_req.sel[`STU_IDX],
                             `STU_DESC_SH'(0)};
            st_d = STU_FETCH;
          end
        end else if (ld_valid) begin
          lflt_d = 1'b1;
        end
      end
      STU_FETCH: begin
        if (df_ack) begin
          seg_d[tgt_q].sel = sel_q;
          seg_d[tgt_q].usable = 1'b1;
          seg_d[tgt_q].desc = fetched;
          done_d = 1'b1;
          st_d = STU_IDLE;
        end
      end
      default: begin
        st_d = STU_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= STU_IDLE;
      tgt_q <= `STU_SEG_CODE;
      sel_q <= 16'h0000;
      dfa_q <= `STU_RST_WORD;
      done_q <= 1'b0;
      lflt_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tgt_q <= tgt_d;
      sel_q <= sel_d;
      dfa_q <= dfa_d;
      done_q <= done_d;
      lflt_q <= lflt_d;
    end
  end

  // Code starts flat and usable; the others start null
  for (genvar g = 0; g < `STU_NSEG; g++) begin : g_seg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        seg_q[g].sel <= 16'h0000;
        seg_q[g].usable <= (g == 0);
        seg_q[g].desc.base <= `STU_RST_WORD;
        seg_q[g].desc.limit <= `STU_RST_LIM;
        seg_q[g].desc.gran <= 1'b1;
        seg_q[g].desc.xdown <= 1'b0;
        seg_q[g].desc.dpl <= 2'h0;
      end else begin
        seg_q[g] <= seg_d[g];
      end
    end
  end

  // Access translation and checks
  stu_seg_t cur;
  logic [32:0] last;
  logic [31:0] elim;
  logic [1:0] eff_pl;
  logic lim_bad;
  stu_fault_t aflt;
  logic [31:0] addr_d, addr_q;
  logic pv_d, pv_q, gv_d, gv_q, gp_d, gp_q;
  stu_fault_t fk_d, fk_q;

  always_comb begin
    cur = seg_q[0];
    if (acc_req.seg < `STU_SEG_W'(`STU_NSEG)) begin
      cur = seg_q[acc_req.seg];
    end
    // Carry out of the last byte also counts as past the end
    last = {1'b0, acc_req.off} + {31'h0000_0000, acc_req.len};
    elim = cur.desc.gran ? {cur.desc.limit, `STU_PG_ONES}
           : {12'h000, cur.desc.limit};
    if (cur.desc.xdown) begin
      lim_bad = last[32] || acc_req.off <= elim;
    end else begin
      lim_bad = last[32] || last[31:0] > elim;
    end
    eff_pl = ctrl_q[`STU_CTRL_CPL];
    if (cur.sel[`STU_RPL] > eff_pl) begin
      eff_pl = cur.sel[`STU_RPL];
    end
    if (!cur.usable) begin
      aflt = STU_F_NULL;
    end else if (lim_bad) begin
      aflt = STU_F_LIMIT;
    end else if (eff_pl > cur.desc.dpl) begin
      aflt = STU_F_PRIV;
    end else begin
      aflt = STU_F_NONE;
    end
  end

  always_comb begin
    addr_d = addr_q;
    pv_d = 1'b0;
    gv_d = 1'b0;
    gp_d = 1'b0;
    fk_d = fk_q;
    last_d = last_q;
    if (acc_valid && aflt != STU_F_NONE) begin
      gp_d = 1'b1;
      fk_d = aflt;
      last_d = aflt;
    end else if (acc_valid) begin
      addr_d = acc_req.off + cur.desc.base;
      pv_d = !ctrl_q[`STU_CTRL_PG];
      gv_d = ctrl_q[`STU_CTRL_PG];
    end else if (lflt_q) begin
      gp_d = 1'b1;
      fk_d = STU_F_LDNULL;
      last_d = STU_F_LDNULL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= `STU_RST_WORD;
      pv_q <= 1'b0;
      gv_q <= 1'b0;
      gp_q <= 1'b0;
      fk_q <= STU_F_NONE;
      last_q <= STU_F_NONE;
    end else begin
      addr_q <= addr_d;
      pv_q <= pv_d;
      gv_q <= gv_d;
      gp_q <= gp_d;
      fk_q <= fk_d;
      last_q <= last_d;
    end
  end

  assign out_addr = addr_q;
  assign phys_valid = pv_q;
  assign page_valid = gv_q;
  assign gp_fault = gp_q;
  assign fault_kind = fk_q;

endmodule : stu_top

// File: verification/stu_mem.sv
// Descriptor fetch bus model with adjustable latency
`timescale 1ns/1ps
module stu_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic df_req,
  input wire logic [31:0] df_addr,
  input wire logic [2:0] delay,
  output logic df_ack,
  output logic [63:0] df_data
);
  logic [63:0] mem [logic [31:0]];
  logic [2:0] cnt_q;
  // Data toggle outside the answer so a stale word never passes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
      df_ack <= 1'b0;
      df_data <= 64'h0;
    end else begin
      df_ack <= 1'b0;
      df_data <= ~df_data;
      if (df_req && !df_ack) begin
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == delay) begin
          cnt_q <= 3'h0;
          df_ack <= 1'b1;
          df_data <= mem.exists(df_addr) ? mem[df_addr] : 64'h0;
        end
      end
    end
  end
endmodule : stu_mem

// File: verification/stu_properties.sv
// Port-level checks of the segment translation unit
`timescale 1ns/1ps
module stu_properties import stu_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ld_valid,
  input wire stu_ld_t ld_req,
  input wire logic ld_ready,
  input wire logic ld_done,
  input wire logic ld_fault,
  input wire logic df_req,
  input wire logic [31:0] df_addr,
  input wire logic df_ack,
  input wire logic acc_valid,
  input wire logic phys_valid,
  input wire logic page_valid,
  input wire logic [31:0] out_addr,
  input wire logic gp_fault
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic take;
  logic nul;
  assign take = ld_valid && ld_ready;
  assign nul = ld_req.sel[15:2] == 14'h0;
  property p_answer;
    acc_valid |=> $onehot({phys_valid, page_valid, gp_fault});
  endproperty
  property p_quiet;
    !acc_valid |=> !phys_valid && !page_valid;
  endproperty
  property p_hold;
    df_req && !df_ack |=> df_req && $stable(df_addr);
  endproperty
  property p_done;
    df_req && df_ack |=> ld_done && !df_req;
  endproperty
  property p_busy;
    df_req |-> !ld_ready;
  endproperty
  property p_nulld;
    take && nul && !ld_req.far && ld_req.seg inside {[3'h2:3'h5]}
      |=> ld_done && !df_req;
  endproperty
  property p_nullc;
    take && nul && (ld_req.far || ld_req.seg < 3'h2) |-> ##[1:2] ld_fault;
  endproperty
  property p_fetch;
    take && !nul && (ld_req.far || ld_req.seg < 3'h6) |=> df_req;
  endproperty
  property p_still;
    gp_fault |-> $stable(out_addr);
  endproperty
  a_answer: assert property (p_answer) else $error("answer");
  a_quiet: assert property (p_quiet) else $error("stray valid");
  a_hold: assert property (p_hold) else $error("fetch dropped");
  a_done: assert property (p_done) else $error("no load done");
  a_busy: assert property (p_busy) else $error("ready in fetch");
  a_nulld: assert property (p_nulld) else $error("null data");
  a_nullc: assert property (p_nullc) else $error("null code");
  a_fetch: assert property (p_fetch) else $error("no fetch");
  a_still: assert property (p_still) else $error("addr moved");
  c_fetch: cover property (take ##1 df_req);
  c_gp: cover property (acc_valid ##1 gp_fault);
  c_page: cover property (acc_valid ##1 page_valid);
  c_ldflt: cover property (take ##1 ld_fault);
endmodule : stu_properties

// File: verification/stu_top_tb.sv
// Directed bench for the segment translation unit
`timescale 1ns/1ps
module stu_top_tb import stu_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, df_addr, out_addr, rd;
  logic [3:0] pstrb;
  logic ld_valid, ld_ready, ld_done, ld_fault, df_req, df_ack;
  logic acc_valid, phys_valid, page_valid, gp_fault;
  logic [63:0] df_data;
  logic [2:0] delay;
  stu_ld_t ld_req;
  stu_acc_t acc_req;
  stu_fault_t fault_kind;
  int error_cnt, compares;
  stu_top i_stu_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .ld_valid, .ld_req,
    .ld_ready, .ld_done, .ld_fault, .df_req, .df_addr, .df_ack, .df_data,
    .acc_valid, .acc_req, .phys_valid, .page_valid, .out_addr, .gp_fault,
    .fault_kind);
  stu_mem i_stu_mem (.pclk, .presetn, .df_req, .df_addr, .delay, .df_ack,
    .df_data);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic end_sim();
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(int n);
    if (n > 15) begin
      error_cnt++;
      end_sim();
    end
  endtask : tmo
  function automatic logic [63:0] dsc(logic [31:0] b, logic [19:0] l,
    logic [3:0] t, logic [1:0] dp, logic g);
    dsc = {b[31:24], g, 3'h0, l[19:16], 1'b1, dp, 1'b1, t, b[23:0], l[15:0]};
  endfunction : dsc
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    tmo(n);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic load(logic f, logic [2:0] s, logic [15:0] sl,
    logic [31:0] ea, logic ef);
    int n;
    logic [31:0] a;
    n = 0;
    a = 32'h0;
    @(posedge pclk);
    ld_valid <= 1'b1;
    ld_req <= {f, s, sl};
    do begin
      @(posedge pclk);
      n++;
    end while (ld_ready !== 1'b1 && n < 16);
    tmo(n);
    ld_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (df_req === 1'b1) a = df_addr;
    end while (ld_done !== 1'b1 && ld_fault !== 1'b1 && n < 16);
    tmo(n);
    chk({31'h0, ld_fault}, {31'h0, ef});
    chk(a, ea);
  endtask : load
  // Outputs are read one edge after the taking edge has settled
  task automatic acc(logic [2:0] s, logic [31:0] o, logic [1:0] l,
    logic [2:0] e3, logic [31:0] ev);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_req <= {s, o, l};
    @(posedge pclk);
    acc_valid <= 1'b0;
    @(posedge pclk);
    chk({29'h0, phys_valid, page_valid, gp_fault}, {29'h0, e3});
    chk(e3[0] ? {29'h0, fault_kind} : out_addr, ev);
  endtask : acc
  initial begin
    {psel, penable, pwrite, ld_valid, acc_valid, presetn} = 6'h0;
    {paddr, pwdata, ld_req, acc_req, delay} = '0;
    pstrb = 4'hf;
    error_cnt = 0;
    compares = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 32'h00, 32'h1000);
    apb(1'b1, 32'h04, 32'h2000);
    apb(1'b0, 32'h04, 32'h0);
    chk(rd, 32'h2000);
    apb(1'b0, 32'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    acc(3'h0, 32'h100, 2'h3, 3'b100, 32'h100);
    acc(3'h2, 32'h0, 2'h0, 3'b001, 32'h1);
    i_stu_mem.mem[32'h1010] = dsc(32'h12345600, 20'h100ff, 4'h2, 2'h3, 1'b0);
    i_stu_mem.mem[32'h2008] = dsc(32'h10000, 20'h1, 4'h6, 2'h0, 1'b1);
    load(1'b0, 3'h2, 16'h0010, 32'h1010, 1'b0);
    acc(3'h2, 32'h100fc, 2'h3, 3'b100, 32'h123556fc);
    acc(3'h2, 32'h100fd, 2'h3, 3'b001, 32'h2);
    i_stu_mem.mem[32'h1010] = dsc(32'habc000, 20'hfffff, 4'ha, 2'h0, 1'b1);
    acc(3'h2, 32'h0, 2'h0, 3'b100, 32'h12345600);
    load(1'b0, 3'h4, 16'h000c, 32'h2008, 1'b0);
    acc(3'h4, 32'h1fff, 2'h0, 3'b001, 32'h2);
    acc(3'h4, 32'h2000, 2'h0, 3'b100, 32'h12000);
    load(1'b0, 3'h5, 16'h000f, 32'h2008, 1'b0);
    acc(3'h5, 32'h2000, 2'h0, 3'b001, 32'h3);
    delay <= 3'h3;
    load(1'b0, 3'h3, 16'hfff8, 32'h10ff8, 1'b0);
    delay <= 3'h0;
    load(1'b0, 3'h3, 16'h0000, 32'h0, 1'b0);
    acc(3'h3, 32'h0, 2'h0, 3'b001, 32'h1);
    load(1'b0, 3'h1, 16'h0003, 32'h0, 1'b1);
    apb(1'b0, 32'h0c, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, 32'h14, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 32'h18, 32'h0);
    chk(rd, 32'h0010);
    apb(1'b1, 32'h08, 32'h1);
    acc(3'h0, 32'h10, 2'h1, 3'b010, 32'h10);
    load(1'b1, 3'h2, 16'h0010, 32'h1010, 1'b0);
    acc(3'h0, 32'h20, 2'h0, 3'b010, 32'habc020);
    acc(3'h2, 32'h0, 2'h0, 3'b010, 32'h12345600);
    // Current level 3 with paging off; upper bits must not stick
    apb(1'b1, 32'h08, 32'hffff_fff6);
    apb(1'b0, 32'h08, 32'h0);
    chk(rd, 32'h6);
    acc(3'h2, 32'h4, 2'h0, 3'b100, 32'h12345604);
    acc(3'h4, 32'h2000, 2'h0, 3'b001, 32'h3);
    load(1'b0, 3'h6, 16'h0010, 32'h0, 1'b1);
    pstrb <= 4'h1;
    apb(1'b1, 32'h04, 32'hffff_ff55);
    pstrb <= 4'hf;
    apb(1'b0, 32'h04, 32'h0);
    chk(rd, 32'h2055);
    apb(1'b1, 32'h40, 32'h1);
    chk({31'h0, er}, 32'h1);
    end_sim();
  end
endmodule : stu_top_tb
bind stu_top stu_properties i_stu_properties (.pclk, .presetn, .ld_valid,
  .ld_req, .ld_ready, .ld_done, .ld_fault, .df_req, .df_addr, .df_ack,
  .acc_valid, .phys_valid, .page_valid, .out_addr, .gp_fault);
